// ==== common/psr_pkg.sv ====
// Shared constants for the pressure setpoint relay controller.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register slave.
package psr_pkg;
    // ========================================================
    // Sizes
    localparam int NUM_RELAYS      = 12;
    localparam int RELAYS_PER_MOD  = 4;
    localparam int NUM_MODULES     = 3;
    localparam int SENS_PER_MOD    = 2;
    localparam int NUM_SENSORS     = NUM_MODULES * SENS_PER_MOD;
    localparam int PRESS_W         = 16;

    // ========================================================
    // Timing: clock rate and evaluation period
    localparam longint CLK_HZ        = 100000000;
    localparam int     EVAL_MS       = 50;   // Decision period, half of the 100 ms bound
    localparam int     HOLD_MS       = 20;   // Power-up open hold
    localparam int     EVAL_CYCLES   = int'(EVAL_MS * CLK_HZ / 1000);
    localparam int     HOLD_CYCLES   = int'(HOLD_MS * CLK_HZ / 1000);
    localparam int     CNT_W         = 32;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] REG_SETPOINT  = 8'h00; // Relay n at n*0x10
    localparam logic [7:0] REG_HYST      = 8'h04;
    localparam logic [7:0] REG_CTRL      = 8'h08;
    localparam logic [7:0] REG_RELAYS    = 8'hc0;
    localparam logic [7:0] REG_MODTYPE   = 8'hc4;
    localparam logic [7:0] REG_STATUS    = 8'hc8;
    localparam logic [7:0] RELAY_SPAN    = 8'h10;
    localparam logic [7:0] RELAY_END     = 8'hc0;

    // ========================================================
    // Field positions and reset values
    localparam int CTRL_DIR_BIT    = 0;
    localparam int CTRL_EN_BIT     = 1;
    localparam int STAT_READY_BIT  = 0;
    localparam int STAT_REJ_BIT    = 1;
    localparam logic [PRESS_W-1:0] SP_RST = 16'h0000;
    localparam logic [PRESS_W-1:0] HY_RST = 16'h0000;
    localparam int HYST_DIV        = 10;  // Default offset, about ten percent

    // ========================================================
    // Enumerations
    typedef enum logic {DIR_BELOW = 1'b0, DIR_ABOVE = 1'b1} psr_dir_type;
    typedef enum logic [1:0] {
        MOD_DUAL = 2'h0,  // Two sensors, two relays each
        MOD_COLD = 2'h1,  // cold_cathode_sensor_module
        MOD_HOT  = 2'h2,  // hot_cathode_sensor_module
        MOD_NONE = 2'h3   // Slot empty, relays held open
    } psr_mod_type;
    localparam psr_mod_type MOD_RST = MOD_NONE;
endpackage : psr_pkg

// ==== hdl/psr_hyst_default.sv ====
// Default hysteresis levels about ten percent either side of a setpoint.
// Pure combinational; the caller picks the side from the direction.
`timescale 1ns/1ps
`default_nettype none
module psr_hyst_default
    import psr_pkg::*;
(
    // Setpoint in
    input  wire logic [PRESS_W-1:0] setpoint,
    // Candidate levels out
    output logic      [PRESS_W-1:0] hy_above,
    output logic      [PRESS_W-1:0] hy_below
);
    // ========================================================
    // Offset arithmetic
    logic [PRESS_W-1:0] offset;   // Tenth of the setpoint
    logic [PRESS_W:0]   sum_wide; // Upper level before saturation

    // Below side must not wrap past full scale, so saturate
    always_comb begin
        offset   = setpoint / PRESS_W'(HYST_DIV);
        sum_wide = {1'b0, setpoint} + {1'b0, offset};
        hy_above = setpoint - offset;
        hy_below = sum_wide[PRESS_W] ? {PRESS_W{1'b1}} : sum_wide[PRESS_W-1:0];
    end
endmodule : psr_hyst_default
`default_nettype wire

// ==== hdl/psr_relay_cell.sv ====
// One setpoint comparator with hysteresis and its held decision.
// Evaluates only on the shared tick; inputs are on the same clock.
`timescale 1ns/1ps
`default_nettype none
module psr_relay_cell
    import psr_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Evaluation strobe
    input  wire logic               tick,
    // Measurement
    input  wire logic [PRESS_W-1:0] pressure,
    input  wire logic               press_ok,
    // Configuration
    input  wire logic               enable,
    input  wire logic               dir_above,
    input  wire logic [PRESS_W-1:0] setpoint,
    input  wire logic [PRESS_W-1:0] hyst,
    // Decision
    output logic                    active_q
);
    // ========================================================
    // Decision register
    // No valid pressure means open, never a guessed value
    always_ff @(posedge clk) begin
        if (!rstn) begin
            active_q <= 1'b0;
        end else if (tick) begin
            if (!enable || !press_ok) begin
                active_q <= 1'b0;
            end else if (dir_above) begin
                if (pressure > setpoint) begin
                    active_q <= 1'b1;
                end else if (pressure <= hyst) begin
                    active_q <= 1'b0;
                end
            end else begin
                if (pressure < setpoint) begin
                    active_q <= 1'b1;
                end else if (pressure >= hyst) begin
                    active_q <= 1'b0;
                end
            end
        end
    end

    // ========================================================
    // Checks
    AST_ABOVE_SET: assert property (@(posedge clk) disable iff (!rstn)
        tick && enable && press_ok && dir_above && pressure > setpoint |=> active_q)
        else $error("above relay did not activate");
    AST_BELOW_SET: assert property (@(posedge clk) disable iff (!rstn)
        tick && enable && press_ok && !dir_above && pressure < setpoint |=> active_q)
        else $error("below relay did not activate");
    AST_BAND_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        tick && enable && press_ok && dir_above && pressure <= setpoint
        && pressure > hyst |=> active_q == $past(active_q))
        else $error("relay changed inside hysteresis band");
    AST_BAND_HOLD_LOW: assert property (@(posedge clk) disable iff (!rstn)
        tick && enable && press_ok && !dir_above && pressure >= setpoint
        && pressure < hyst |=> active_q == $past(active_q))
        else $error("below relay changed inside hysteresis band");
endmodule : psr_relay_cell
`default_nettype wire

// ==== hdl/psr_relays_top.sv ====
// Twelve setpoint relays with Avalon-MM configuration.
// Pressures and validity come from sensor processing on the same clock.
// Relay outputs drive normally open contact drivers, high means closed.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Twelve relays, each individually switched
// - Active relay closes a normally open contact
// - All relays open until decisions valid
// - Change follows measurement within 50-100 ms
// - Four relays per module, dual splits two
// - Each relay has above or below direction
// - Above: activate when pressure exceeds setpoint
// - Below: activate when pressure under setpoint
// - Ion gauge relays allow only below
// - Hysteresis lies on the inactive side; only hysteresis writes are checked, a setpoint write is not
// - Direction change loads ten percent hysteresis
module psr_relays_top
    import psr_pkg::*;
#(
    parameter int EVAL_PERIOD = EVAL_CYCLES,  // Cycles per decision
    parameter int HOLD_PERIOD = HOLD_CYCLES   // Power-up open hold
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rstn,
    // Avalon-MM slave
    input  wire logic [7:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic      [31:0]                  avs_readdata,
    output logic                              avs_waitrequest,
    // Pressures, sensor s at bits s*PRESS_W
    input  wire logic [NUM_SENSORS*PRESS_W-1:0] pressure,
    input  wire logic [NUM_SENSORS-1:0]       pressure_valid,
    // Relay contact drives
    output logic      [NUM_RELAYS-1:0]        relay_close,
    output logic                              relays_ready
);
    // ========================================================
    // Bus handshake
    logic        wait_q;     // Registered waitrequest
    logic [31:0] rdata_q;    // Registered read data
    logic        wr_go;      // Write commits this edge
    logic [31:0] be_mask;    // Byte lanes as bit mask
    logic [3:0]  ridx;       // Relay index from address
    logic [7:0]  roff;       // Field offset inside relay
    logic        in_relay;   // Address hits a relay block

    // One wait cycle per access, so read data are already stable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wait_q <= 1'b1;
        end else if ((avs_read || avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_comb begin
        wr_go    = avs_write && !wait_q;
        ridx     = avs_address[7:4];
        roff     = avs_address & (RELAY_SPAN - 8'h01);
        in_relay = avs_address < RELAY_END;
        for (int b = 0; b < 4; b++) begin
            be_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // ========================================================
    // Configuration registers
    logic [PRESS_W-1:0] sp_q [NUM_RELAYS];   // Setpoints
    logic [PRESS_W-1:0] hy_q [NUM_RELAYS];   // Hysteresis levels
    logic [NUM_RELAYS-1:0] dir_q;            // 1 = above
    logic [NUM_RELAYS-1:0] en_q;             // Relay enable
    psr_mod_type mod_q [NUM_MODULES];        // Module kinds
    logic        rej_q;                      // Sticky rejected write
    logic [PRESS_W-1:0] hy_a [NUM_RELAYS];   // Default for above
    logic [PRESS_W-1:0] hy_b [NUM_RELAYS];   // Default for below
    logic [NUM_RELAYS-1:0] ion;              // Relay on an ion gauge
    logic [NUM_RELAYS-1:0] absent;           // Relay in empty slot
    logic [2:0]  sens_idx [NUM_RELAYS];      // Sensor owning relay
    logic [31:0] wmerge;                     // Lane-merged write word
    logic        new_dir;                    // Requested direction
    logic [PRESS_W-1:0] new_hy;              // Requested hysteresis
    logic        rej_dir;                    // Above refused on ion
    logic        rej_hy;                     // Wrong-side hysteresis

    // Per relay: owning sensor and default levels
    for (genvar r = 0; r < NUM_RELAYS; r++) begin : g_map
        localparam int MOD  = r / RELAYS_PER_MOD;
        localparam int SLOT = r % RELAYS_PER_MOD;
        always_comb begin
            ion[r]    = (mod_q[MOD] == MOD_COLD) || (mod_q[MOD] == MOD_HOT);
            absent[r] = mod_q[MOD] == MOD_NONE;
            // Single module owns all four, dual gives two per sensor
            if (mod_q[MOD] == MOD_DUAL) begin
                sens_idx[r] = 3'(MOD * SENS_PER_MOD + SLOT / 2);
            end else begin
                sens_idx[r] = 3'(MOD * SENS_PER_MOD);
            end
        end
        psr_hyst_default u_hdef (
            .setpoint (sp_q[r]),
            .hy_above (hy_a[r]),
            .hy_below (hy_b[r])
        );
    end

    // Refusals are decided from the merged word of the access
    always_comb begin
        wmerge  = 32'h0000_0000;
        new_dir = 1'b0;
        new_hy  = HY_RST;
        rej_dir = 1'b0;
        rej_hy  = 1'b0;
        if (in_relay) begin
            if (roff == REG_CTRL) begin
                wmerge  = ({30'h0, en_q[ridx], dir_q[ridx]} & ~be_mask)
                        | (avs_writedata & be_mask);
                new_dir = wmerge[CTRL_DIR_BIT];
                rej_dir = wr_go && ion[ridx] && new_dir;
            end else if (roff == REG_HYST) begin
                wmerge  = ({16'h0, hy_q[ridx]} & ~be_mask)
                        | (avs_writedata & be_mask);
                new_hy  = wmerge[PRESS_W-1:0];
                // Above wants level under setpoint, below over it
                rej_hy  = wr_go && (dir_q[ridx] ? new_hy >= sp_q[ridx]
                                               : new_hy <= sp_q[ridx]);
            end else if (roff == REG_SETPOINT) begin
                wmerge  = ({16'h0, sp_q[ridx]} & ~be_mask)
                        | (avs_writedata & be_mask);
            end
        end else if (avs_address == REG_MODTYPE) begin
            wmerge = avs_writedata & be_mask;
        end
    end

    // Relay settings; ion gauges are forced back to below
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_RELAYS; i++) begin
                sp_q[i] <= SP_RST;
                hy_q[i] <= HY_RST;
            end
            dir_q <= '0;
            en_q  <= '0;
        end else begin
            if (wr_go && in_relay) begin
                if (roff == REG_SETPOINT) begin
                    sp_q[ridx] <= wmerge[PRESS_W-1:0];
                end else if (roff == REG_HYST && !rej_hy) begin
                    hy_q[ridx] <= new_hy;
                end else if (roff == REG_CTRL) begin
                    en_q[ridx] <= wmerge[CTRL_EN_BIT];
                    if (!rej_dir && new_dir != dir_q[ridx]) begin
                        dir_q[ridx] <= new_dir;
                        hy_q[ridx]  <= new_dir ? hy_a[ridx]
                                               : hy_b[ridx];
                    end
                end
            end
            for (int i = 0; i < NUM_RELAYS; i++) begin
                if (ion[i] && dir_q[i]) begin
                    dir_q[i] <= 1'b0;
                    hy_q[i]  <= hy_b[i];
                end
            end
        end
    end

    // Module kinds, one field of two bits each
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int m = 0; m < NUM_MODULES; m++) begin
                mod_q[m] <= MOD_RST;
            end
        end else if (wr_go && avs_address == REG_MODTYPE) begin
            for (int m = 0; m < NUM_MODULES; m++) begin
                if (avs_byteenable[0]) begin
                    mod_q[m] <= psr_mod_type'(wmerge[m*2 +: 2]);
                end
            end
        end
    end

    // Refused writes are sticky; a new refusal beats the clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rej_q <= 1'b0;
        end else if (rej_dir || rej_hy) begin
            rej_q <= 1'b1;
        end else if (wr_go && avs_address == REG_STATUS
                     && avs_byteenable[0] && avs_writedata[STAT_REJ_BIT]) begin
            rej_q <= 1'b0;
        end
    end

    // ========================================================
    // Evaluation timing and power-up hold
    logic [CNT_W-1:0] eval_cnt_q;  // Cycles since last decision
    logic             tick_q;      // One-cycle decision strobe
    logic [CNT_W-1:0] hold_cnt_q;  // Power-up hold counter
    logic             hold_done_q; // Hold time elapsed
    logic             first_q;     // A decision has been taken

    // Snapshot at one tick, decided and driven at the next: 50..100 ms
    always_ff @(posedge clk) begin
        if (!rstn) begin
            eval_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (eval_cnt_q == CNT_W'(EVAL_PERIOD - 1)) begin
            eval_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            eval_cnt_q <= eval_cnt_q + CNT_W'(1);
            tick_q     <= 1'b0;
        end
    end

    // Contacts stay open until hold ends and a decision exists
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_cnt_q  <= '0;
            hold_done_q <= 1'b0;
            first_q     <= 1'b0;
        end else begin
            if (hold_cnt_q == CNT_W'(HOLD_PERIOD - 1)) begin
                hold_done_q <= 1'b1;
            end else begin
                hold_cnt_q <= hold_cnt_q + CNT_W'(1);
            end
            if (tick_q && hold_done_q) begin
                first_q <= 1'b1;
            end
        end
    end

    // ========================================================
    // Pressure snapshot and comparators
    logic [PRESS_W-1:0]    snap_q [NUM_SENSORS]; // Captured pressure
    logic [NUM_SENSORS-1:0] snap_ok_q;           // Captured validity
    logic [NUM_RELAYS-1:0] active;               // Cell decisions

    // Latency is deliberately one full period, trading speed for stability
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                snap_q[s] <= '0;
            end
            snap_ok_q <= '0;
        end else if (tick_q) begin
            for (int s = 0; s < NUM_SENSORS; s++) begin
                snap_q[s] <= pressure[s*PRESS_W +: PRESS_W];
            end
            snap_ok_q <= pressure_valid;
        end
    end

    for (genvar r = 0; r < NUM_RELAYS; r++) begin : g_relay
        psr_relay_cell u_cell (
            .clk       (clk),
            .rstn      (rstn),
            .tick      (tick_q),
            .pressure  (snap_q[sens_idx[r]]),
            .press_ok  (snap_ok_q[sens_idx[r]] && !absent[r]),
            .enable    (en_q[r]),
            .dir_above (dir_q[r]),
            .setpoint  (sp_q[r]),
            .hyst      (hy_q[r]),
            .active_q  (active[r])
        );
    end

    // ========================================================
    // Contact drive: high closes the normally open contact
    always_ff @(posedge clk) begin
        if (!rstn) begin
            relay_close  <= '0;
            relays_ready <= 1'b0;
        end else begin
            relay_close  <= first_q ? active : '0;
            relays_ready <= first_q;
        end
    end

    // ========================================================
    // Read data, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && wait_q) begin
            if (in_relay && ridx < 4'(NUM_RELAYS)) begin
                if (roff == REG_SETPOINT) begin
                    rdata_q <= {16'h0, sp_q[ridx]};
                end else if (roff == REG_HYST) begin
                    rdata_q <= {16'h0, hy_q[ridx]};
                end else if (roff == REG_CTRL) begin
                    rdata_q <= {30'h0, en_q[ridx], dir_q[ridx]};
                end else begin
                    rdata_q <= 32'h0000_0000;
                end
            end else if (avs_address == REG_RELAYS) begin
                rdata_q <= {20'h0, relay_close};
            end else if (avs_address == REG_MODTYPE) begin
                rdata_q <= {26'h0, mod_q[2], mod_q[1], mod_q[0]};
            end else if (avs_address == REG_STATUS) begin
                rdata_q <= {30'h0, rej_q, relays_ready};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    always_comb begin
        avs_waitrequest = wait_q;
        avs_readdata    = rdata_q;
    end

    // ========================================================
    // Checks
    AST_OPEN_AT_POWERUP: assert property (@(posedge clk) disable iff (!rstn)
        !hold_done_q |-> relay_close == '0)
        else $error("relay closed during power-up hold");
    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rstn)
        tick_q |=> !tick_q[*2])
        else $error("decision strobes too close");
    AST_ION_BELOW: assert property (@(posedge clk) disable iff (!rstn)
        ion != '0 |=> (dir_q & $past(ion)) == '0)
        else $error("ion gauge relay left in above");
    AST_DIR_DEFAULT: assert property (@(posedge clk) disable iff (!rstn)
        wr_go && in_relay && roff == REG_CTRL && !rej_dir
        && new_dir != dir_q[ridx] && !ion[ridx]
        |=> hy_q[$past(ridx)] == (dir_q[$past(ridx)] ? $past(hy_a[ridx])
                                                     : $past(hy_b[ridx])))
        else $error("hysteresis not defaulted on direction change");
    AST_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
        first_q |=> relay_close == $past(active))
        else $error("contact does not follow decision");
    AST_ONE_WAIT: assert property (@(posedge clk) disable iff (!rstn)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
endmodule : psr_relays_top
`default_nettype wire

// ==== testbench/psr_load_model.sv ====
// Valves and loads switched by the twelve relay contacts.
// Assumes a closed contact powers a normally closed valve solenoid.
`timescale 1ns/1ps
`default_nettype none
module psr_load_model
    import psr_pkg::*;
(
    // Contacts in
    input  wire logic [NUM_RELAYS-1:0] relay_close,
    // Valve state, 1 = open
    output logic      [NUM_RELAYS-1:0] valve_open
);
    // ========================================================
    // Only a closed contact powers a solenoid
    assign valve_open = relay_close;
endmodule : psr_load_model
`default_nettype wire

// ==== testbench/test_pressure_setpoint_relays.sv ====
// Self-checking bench for the setpoint relay controller.
// Assumes 100 MHz clock, short decision and hold periods.
`timescale 1ns/1ps
`default_nettype none
module test_pressure_setpoint_relays
    import psr_pkg::*;
;
    localparam int EP = 20; // Short period keeps the run brief
    logic        clk, rstn, avs_read, avs_write, avs_waitrequest, relays_ready;
    logic [7:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [95:0] pressure;
    logic [5:0]  pressure_valid;
    logic [11:0] relay_close, valve_open;
    int          num_errors, n_checks, n;
    // Row: sensor 0..2 pressures, sensor 2 valid, expected contacts
    typedef struct packed {
        logic [15:0] s0, s1, s2;
        logic        v2;
        logic [11:0] exp;
    } psr_row_type;
    psr_row_type rows [5] = '{
        '{16'h2000, 16'h0800, 16'h0800, 1'b1, 12'h015},
        '{16'h0f00, 16'h1100, 16'h0800, 1'b0, 12'h005},
        '{16'h0e67, 16'h1200, 16'h0800, 1'b1, 12'h010},
        '{16'h1000, 16'h1000, 16'h1000, 1'b1, 12'h010},
        '{16'h1001, 16'h0fff, 16'h1200, 1'b1, 12'h005}};

    psr_relays_top #(.EVAL_PERIOD(EP), .HOLD_PERIOD(10)) i_dut (.clk(clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pressure(pressure), .pressure_valid(pressure_valid),
        .relay_close(relay_close), .relays_ready(relays_ready));
    psr_load_model i_load (.relay_close(relay_close), .valve_open(valve_open));

    // ========================================================
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Used-up wait bound ends the run
    task automatic lim(input int k);
        if (k >= 200) begin
            num_errors++;
            finish_test();
        end
    endtask : lim

    // One bus access; hold until waitrequest sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 200);
        lim(k);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // ========================================================
    // Main sequence
    initial begin
        {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        pressure = '0;
        pressure_valid = '0;
        num_errors = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        chk(relay_close, 32'h0);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk(relays_ready, 32'h0);
        for (n = 0; relays_ready !== 1'b1 && n < 200; n++) @(posedge clk);
        lim(n);
        // Slot 0 dual, slot 1 cold cathode, slot 2 empty
        bus(1'b1, REG_MODTYPE, 32'h34);
        bus(1'b1, REG_SETPOINT, 32'h1000);
        bus(1'b1, REG_CTRL, 32'h3);
        bus(1'b0, REG_HYST, 32'h0);
        chk(q, 32'h0e67);
        bus(1'b1, 8'h20, 32'h1000);
        bus(1'b1, 8'h24, 32'h1200);
        bus(1'b1, 8'h28, 32'h2);
        bus(1'b1, 8'h24, 32'h0800);
        bus(1'b0, 8'h24, 32'h0);
        chk(q, 32'h1200);
        // Above on an ion gauge relay must bounce
        bus(1'b1, 8'h48, 32'h3);
        bus(1'b0, 8'h48, 32'h0);
        chk(q[0], 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[1:0], 32'h3);
        bus(1'b1, 8'h40, 32'h1000);
        bus(1'b1, 8'h44, 32'h1200);
        bus(1'b1, 8'h48, 32'h2);
        // Relay 8 sits in the empty slot: enabled, yet must stay open
        bus(1'b1, 8'h80, 32'h1000);
        bus(1'b1, 8'h88, 32'h2);
        foreach (rows[i]) begin
            @(posedge clk);
            pressure       <= {48'h0, rows[i].s2, rows[i].s1, rows[i].s0};
            pressure_valid <= {3'b111, rows[i].v2, 2'b11};
            repeat (3 * EP) @(posedge clk);
            chk(relay_close, rows[i].exp);
        end
        bus(1'b0, REG_RELAYS, 32'h0);
        chk(q, 32'h005);
        chk(valve_open, 32'h005);
        // Release delay lies within one to two periods
        pressure[15:0] <= 16'h0e00;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (relay_close[0] !== 1'b0 && n < 200);
        chk(n >= EP && n <= 2 * EP + 4, 32'h1);
        // Hot cathode in slot 0 forces relay 0 back to below
        bus(1'b1, REG_MODTYPE, 32'h36);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h2);
        bus(1'b0, REG_HYST, 32'h0);
        chk(q, 32'h1199);
        bus(1'b0, 8'hcc, 32'h0);
        chk(q, 32'h0);
        // Mid-run reset opens every contact and empties the slots
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk({relays_ready, relay_close}, 32'h0);
        rstn <= 1'b1;
        bus(1'b0, REG_MODTYPE, 32'h0);
        chk(q, 32'h3f);
        finish_test();
    end
endmodule : test_pressure_setpoint_relays
`default_nettype wire
